// *** common/sarp_pkg.sv ***
// Purpose: Shared constants and types of the symmetric/AEAD request parser
// Assumes: Word-wide register bus, byte offsets in an 8-bit window
// Notes:   Opcode, flag and status encodings are local choices
package sarp_pkg;
  // Fixed header sizes in bytes and words
  localparam int FLF_STATELESS_BYTES = 72;
  localparam int FLF_SESSION_BYTES   = 40;
  localparam int FLF_WORDS           = FLF_STATELESS_BYTES / 4;
  localparam int FLF_SESS_WORDS      = FLF_SESSION_BYTES / 4;
  localparam logic [31:0] AEAD_IV_ALLOC_BYTES = 32'h0000_0010;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_OPCODE     = 8'h04;
  localparam logic [7:0] REG_FLAG       = 8'h08;
  localparam logic [7:0] REG_SESSION    = 8'h0C;
  localparam logic [7:0] REG_SYM_OP     = 8'h10;
  localparam logic [7:0] REG_STATUS     = 8'h14;
  localparam logic [7:0] REG_SESS_CFG   = 8'h18;
  localparam logic [7:0] REG_KEY_OFF    = 8'h20;
  localparam logic [7:0] REG_AUTH_OFF   = 8'h24;
  localparam logic [7:0] REG_IV_OFF     = 8'h28;
  localparam logic [7:0] REG_AAD_OFF    = 8'h2C;
  localparam logic [7:0] REG_SRC_OFF    = 8'h30;
  localparam logic [7:0] REG_TAG_OFF    = 8'h34;
  localparam logic [7:0] REG_HASH_OFF   = 8'h38;
  localparam logic [7:0] REG_IV_UPDATES = 8'h3C;
  localparam logic [7:0] REG_FIXED_BASE = 8'h40;

  // Field positions
  localparam int CTRL_START_BIT     = 0;
  localparam int CTRL_CIPHER_SL_BIT = 1;
  localparam int CTRL_AEAD_SL_BIT   = 2;
  localparam int SESS_VALID_BIT     = 16;
  localparam int SESS_CCM_BIT       = 17;

  // Header encodings
  localparam logic [31:0] OPC_CIPHER_ENCRYPT = 32'h0000_0100;
  localparam logic [31:0] OPC_CIPHER_DECRYPT = 32'h0000_0101;
  localparam logic [31:0] OPC_AEAD_ENCRYPT   = 32'h0000_0200;
  localparam logic [31:0] OPC_AEAD_DECRYPT   = 32'h0000_0201;
  localparam logic [31:0] FLAG_STATELESS     = 32'h0000_0000;
  localparam logic [31:0] FLAG_SESSION_MODE  = 32'h0000_0001;
  localparam logic [31:0] SYM_OP_CIPHER      = 32'h0000_0001;
  localparam logic [31:0] SYM_OP_CHAIN       = 32'h0000_0002;
  localparam logic [31:0] ALGO_NONE          = 32'h0000_0000;
  localparam logic [31:0] AEAD_ALGO_CCM      = 32'h0000_0002;

  // Completion status codes
  localparam logic [3:0] STATUS_OK              = 4'h0;
  localparam logic [3:0] STATUS_ERROR           = 4'h1;
  localparam logic [3:0] STATUS_BAD_MESSAGE     = 4'h2;
  localparam logic [3:0] STATUS_UNSUPPORTED     = 4'h3;
  localparam logic [3:0] STATUS_INVALID_SESSION = 4'h4;

  typedef enum logic [1:0] {KIND_CIPHER, KIND_CHAIN, KIND_AEAD} sarp_kind_t;
endpackage

// *** design/sarp_ahb_front.sv ***
// Purpose: AHB-Lite address phase capture for the parser registers
// Assumes: Zero-wait slave, single word transfers only
// Notes:   Write data is applied in the data phase that follows
module sarp_ahb_front
  import sarp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic        hready_in,
  output logic             wr_pend_out,
  output logic [7:0]       wr_addr_out,
  output logic             rd_now_out,
  output logic [7:0]       rd_addr_out
);
  typedef struct packed {
    logic       wpend;
    logic [7:0] waddr;
  } sarp_front_t;

  sarp_front_t s;
  sarp_front_t next_s;
  logic        accept;

  // NONSEQ or SEQ accepted only when the bus is ready
  assign accept      = hsel_in && htrans_in[1] && hready_in;
  assign rd_now_out  = accept && !hwrite_in;
  assign rd_addr_out = haddr_in;
  assign wr_pend_out = s.wpend;
  assign wr_addr_out = s.waddr;

  // Hold a write address until its data phase
  always_comb
  begin
    next_s = s;
    if (hready_in)
    begin
      next_s.wpend = accept && hwrite_in;
      next_s.waddr = haddr_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else if (ce_in)
      s <= next_s;
  end
endmodule

// *** design/sarp_session_table.sv ***
// Purpose: Table of live session identifiers with their AEAD mode
// Assumes: Software fills entries when a session is created
// Notes:   Identifiers beyond the table depth never match
module sarp_session_table
  import sarp_pkg::*;
#(
  parameter int IDX_W = 4
)
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic        wr_en_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [31:0] rd_id_in,
  output logic             rd_hit_out,
  output logic             rd_ccm_out
);
  localparam int DEPTH = 1 << IDX_W;

  typedef struct packed {
    logic [DEPTH-1:0] valid;
    logic [DEPTH-1:0] ccm;
  } sarp_sess_t;

  sarp_sess_t       s;
  sarp_sess_t       next_s;
  logic [IDX_W-1:0] widx;
  logic [IDX_W-1:0] ridx;
  logic             in_range;

  assign widx       = wr_data_in[IDX_W-1:0];
  assign ridx       = rd_id_in[IDX_W-1:0];
  assign in_range   = (rd_id_in >> IDX_W) == 32'h0000_0000;
  assign rd_hit_out = in_range && s.valid[ridx];
  assign rd_ccm_out = s.ccm[ridx];

  // One entry per write: valid and mode bits
  always_comb
  begin
    next_s = s;
    if (wr_en_in)
    begin
      next_s.valid[widx] = wr_data_in[SESS_VALID_BIT];
      next_s.ccm[widx]   = wr_data_in[SESS_CCM_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else if (ce_in)
      s <= next_s;
  end
endmodule

// *** design/sarp_parser.sv ***
// Purpose: Decode symmetric and AEAD requests, lay out buffers, report status
// Assumes: Crypto core and memory mover on the same clock, software on AHB-Lite
// Notes:   Offsets are byte positions in the readable and writable areas
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.

module sarp_parser
  import sarp_pkg::*;
#(
  parameter int SESS_IDX_W = 4
)
(
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 ce_in,
  input  wire logic                 hsel_in,
  input  wire logic [31:0]          haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic [31:0]               hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  input  wire logic                 core_partial_in,
  input  wire logic                 core_done_in,
  input  wire logic                 core_tag_ok_in,
  input  wire logic                 core_error_in,
  input  wire logic                 core_wr_busy_in,
  output logic                      core_start_out,
  output sarp_pkg::sarp_kind_t      core_kind_out,
  output logic                      core_decrypt_out,
  output logic                      core_aad_en_out,
  output logic                      core_ccm_out,
  output logic                      iv_update_out,
  output logic                      status_valid_out,
  output logic [3:0]                status_code_out
);
  typedef enum logic [2:0] {S_IDLE, S_DECODE, S_RUN, S_DRAIN, S_FINISH} sarp_fsm_t;

  typedef struct packed {
    sarp_fsm_t                  state;
    logic                       cipher_sl;
    logic                       aead_sl;
    logic [31:0]                opcode;
    logic [31:0]                flag;
    logic [31:0]                session;
    logic [31:0]                sym_op;
    logic [FLF_WORDS-1:0][31:0] fixed;
    logic                       busy;
    logic                       done;
    logic [3:0]                 status;
    sarp_kind_t                 kind;
    logic                       decrypt;
    logic                       aad_en;
    logic                       ccm;
    logic [31:0]                auth_off;
    logic [31:0]                iv_off;
    logic [31:0]                aad_off;
    logic [31:0]                src_off;
    logic [31:0]                tag_off;
    logic [31:0]                hash_off;
    logic [15:0]                iv_updates;
    logic                       core_start;
    logic                       iv_update;
    logic                       status_valid;
    logic [31:0]                hrdata;
  } sarp_state_t;

  sarp_state_t s;
  sarp_state_t next_s;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        rd_now;
  logic [7:0]  rd_addr;
  logic        sess_hit;
  logic        sess_ccm;

  // Opcode classes, used by decode and negotiation select
  function automatic logic is_aead(input logic [31:0] op);
    return (op == OPC_AEAD_ENCRYPT) || (op == OPC_AEAD_DECRYPT);
  endfunction

  function automatic logic is_cipher(input logic [31:0] op);
    return (op == OPC_CIPHER_ENCRYPT) || (op == OPC_CIPHER_DECRYPT);
  endfunction

  // Register read view; reserved bits and holes read as zero
  function automatic logic [31:0] read_reg(input sarp_state_t st, input logic [7:0] a);
    logic [31:0] v;
    logic [7:0]  widx;
    v    = 32'h0000_0000;
    widx = 8'((a - REG_FIXED_BASE) >> 2);
    if (a >= REG_FIXED_BASE && widx < 8'(FLF_WORDS))
      v = st.fixed[widx[4:0]];
    else
      case (a)
        REG_CTRL:       v = {29'h0, st.aead_sl, st.cipher_sl, 1'b0};
        REG_OPCODE:     v = st.opcode;
        REG_FLAG:       v = st.flag;
        REG_SESSION:    v = st.session;
        REG_SYM_OP:     v = st.sym_op;
        REG_STATUS:     v = {24'h0, st.status, 2'h0, st.done, st.busy};
        REG_KEY_OFF:    v = 32'h0000_0000;
        REG_AUTH_OFF:   v = st.auth_off;
        REG_IV_OFF:     v = st.iv_off;
        REG_AAD_OFF:    v = st.aad_off;
        REG_SRC_OFF:    v = st.src_off;
        REG_TAG_OFF:    v = st.tag_off;
        REG_HASH_OFF:   v = st.hash_off;
        REG_IV_UPDATES: v = {16'h0, st.iv_updates};
        default:        v = 32'h0000_0000;
      endcase
    return v;
  endfunction

  sarp_ahb_front u_front (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .ce_in       (ce_in),
    .hsel_in     (hsel_in),
    .htrans_in   (htrans_in),
    .hwrite_in   (hwrite_in),
    .haddr_in    (haddr_in[7:0]),
    .hready_in   (hready_in),
    .wr_pend_out (wr_pend),
    .wr_addr_out (wr_addr),
    .rd_now_out  (rd_now),
    .rd_addr_out (rd_addr)
  );

  sarp_session_table #(.IDX_W(SESS_IDX_W)) u_sess (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .wr_en_in   (wr_pend && wr_addr == REG_SESS_CFG),
    .wr_data_in (hwdata_in),
    .rd_id_in   (s.session),
    .rd_hit_out (sess_hit),
    .rd_ccm_out (sess_ccm)
  );

  // Bus response outputs tied off; the rest straight from the state register
  assign hrdata_out       = s.hrdata;
  assign hreadyout_out    = 1'b1;
  assign hresp_out        = 1'b0;
  assign core_start_out   = s.core_start;
  assign core_kind_out    = s.kind;
  assign core_decrypt_out = s.decrypt;
  assign core_aad_en_out  = s.aad_en;
  assign core_ccm_out     = s.ccm;
  assign iv_update_out    = s.iv_update;
  assign status_valid_out = s.status_valid;
  assign status_code_out  = s.status;

  // Register writes, request decode and completion sequencing
  always_comb
  begin
    logic [7:0]  widx;
    logic        aead;
    logic        neg;
    logic        sl;
    logic        bad_flag;
    logic        unsupp;
    sarp_kind_t  kind;
    logic [31:0] algo;
    logic [31:0] klen;
    logic [31:0] aklen;
    logic [31:0] ivl;
    logic [31:0] aadl;
    logic [31:0] srcl;
    logic [31:0] dstl;
    logic [31:0] tagl;
    logic [31:0] iv_area;
    logic [31:0] after_iv;
    widx     = 8'((wr_addr - REG_FIXED_BASE) >> 2);
    aead     = is_aead(s.opcode);
    neg      = aead ? s.aead_sl : s.cipher_sl;
    sl       = neg && s.flag == FLAG_STATELESS;
    bad_flag = neg && s.flag != FLAG_STATELESS && s.flag != FLAG_SESSION_MODE;
    unsupp   = !aead && !is_cipher(s.opcode);
    kind     = aead ? KIND_AEAD : (s.sym_op == SYM_OP_CHAIN ? KIND_CHAIN : KIND_CIPHER);
    algo     = ALGO_NONE;
    klen     = 32'h0;
    aklen    = 32'h0;
    ivl      = 32'h0;
    aadl     = 32'h0;
    srcl     = 32'h0;
    dstl     = 32'h0;
    tagl     = 32'h0;
    next_s              = s;
    next_s.core_start   = 1'b0;
    next_s.iv_update    = 1'b0;
    next_s.status_valid = 1'b0;

    // Software writes; request contents are frozen while busy
    if (wr_pend)
    begin
      if (wr_addr == REG_CTRL)
      begin
        next_s.cipher_sl = hwdata_in[CTRL_CIPHER_SL_BIT];
        next_s.aead_sl   = hwdata_in[CTRL_AEAD_SL_BIT];
        if (hwdata_in[CTRL_START_BIT] && s.state == S_IDLE)
        begin
          next_s.state = S_DECODE;
          next_s.busy  = 1'b1;
          next_s.done  = 1'b0;
        end
      end
      else if (!s.busy)
      begin
        if (wr_addr >= REG_FIXED_BASE && widx < 8'(FLF_WORDS))
          next_s.fixed[widx[4:0]] = hwdata_in;
        else if (wr_addr == REG_OPCODE)
          next_s.opcode = hwdata_in;
        else if (wr_addr == REG_FLAG)
          next_s.flag = hwdata_in;
        else if (wr_addr == REG_SESSION)
          next_s.session = hwdata_in;
        else if (wr_addr == REG_SYM_OP)
          next_s.sym_op = hwdata_in;
      end
    end

    // Field extraction per structure; words past each layout never read
    case (kind)
      KIND_CIPHER:
        if (sl)
        begin
          algo = s.fixed[0];
          klen = s.fixed[1];
          ivl  = s.fixed[3];
          srcl = s.fixed[4];
          dstl = s.fixed[5];
        end
        else
        begin
          ivl  = s.fixed[0];
          srcl = s.fixed[1];
          dstl = s.fixed[2];
        end
      KIND_CHAIN:
        if (sl)
        begin
          algo  = s.fixed[2];
          klen  = s.fixed[3];
          aklen = s.fixed[6];
          ivl   = s.fixed[8];
          srcl  = s.fixed[9];
          dstl  = s.fixed[10];
          aadl  = s.fixed[15];
          tagl  = s.fixed[16];
        end
        else
        begin
          ivl  = s.fixed[0];
          srcl = s.fixed[1];
          dstl = s.fixed[2];
          aadl = s.fixed[7];
          tagl = s.fixed[8];
        end
      default:
        if (sl)
        begin
          algo = s.fixed[0];
          klen = s.fixed[1];
          ivl  = s.fixed[3];
          tagl = s.fixed[4];
          aadl = s.fixed[5];
          srcl = s.fixed[6];
          dstl = s.fixed[7];
        end
        else
        begin
          ivl  = s.fixed[0];
          aadl = s.fixed[1];
          srcl = s.fixed[2];
          dstl = s.fixed[3];
          tagl = s.fixed[4];
        end
    endcase

    // AEAD always reserves a full IV area regardless of its length
    iv_area  = (kind == KIND_AEAD) ? AEAD_IV_ALLOC_BYTES : ivl;
    after_iv = klen + aklen + iv_area;

    unique case (s.state)
      S_IDLE:
      begin
      end
      S_DECODE:
      begin
        // Readable areas: cipher key at zero, then auth key, IV, AAD/source
        next_s.kind     = kind;
        next_s.decrypt  = (s.opcode == OPC_CIPHER_DECRYPT) || (s.opcode == OPC_AEAD_DECRYPT);
        next_s.aad_en   = (kind != KIND_CIPHER) && (aadl > 32'h0);
        next_s.ccm      = (kind == KIND_AEAD) && (sl ? algo == AEAD_ALGO_CCM : sess_ccm);
        next_s.auth_off = klen;
        next_s.iv_off   = klen + aklen;
        if (sl && kind == KIND_CHAIN)
        begin
          next_s.aad_off = after_iv;
          next_s.src_off = after_iv + aadl;
        end
        else
        begin
          next_s.src_off = after_iv;
          next_s.aad_off = after_iv + srcl;
        end
        // Writable area: result at zero, tag after result, hash after dest
        next_s.tag_off  = srcl;
        next_s.hash_off = dstl;
        next_s.iv_updates = 16'h0;
        // Unsupported first, then bad flag, then session, then short destination
        if (unsupp || (sl && algo == ALGO_NONE) ||
            (!aead && s.sym_op != SYM_OP_CIPHER && s.sym_op != SYM_OP_CHAIN))
        begin
          next_s.status = STATUS_UNSUPPORTED;
          next_s.state  = S_FINISH;
        end
        else if (bad_flag)
        begin
          next_s.status = STATUS_ERROR;
          next_s.state  = S_FINISH;
        end
        else if (!sl && !sess_hit)
        begin
          next_s.status = STATUS_INVALID_SESSION;
          next_s.state  = S_FINISH;
        end
        else if (kind == KIND_AEAD && dstl < srcl + tagl)
        begin
          next_s.status = STATUS_ERROR; // Destination too small for tag
          next_s.state  = S_FINISH;
        end
        else
        begin
          next_s.status     = STATUS_OK;
          next_s.core_start = 1'b1;
          next_s.state      = S_RUN;
        end
      end
      S_RUN:
      begin
        // Each partial pass rewrites the IV or counter in memory
        if (core_partial_in)
        begin
          next_s.iv_update  = 1'b1;
          next_s.iv_updates = s.iv_updates + 16'h1;
        end
        if (core_done_in)
        begin
          if (core_error_in)
            next_s.status = STATUS_ERROR;
          else if (s.kind == KIND_AEAD && s.decrypt && !core_tag_ok_in)
            next_s.status = STATUS_BAD_MESSAGE;
          next_s.state = S_DRAIN;
        end
      end
      S_DRAIN:
      begin
        // Hold status back until every output byte has landed
        if (!core_wr_busy_in)
          next_s.state = S_FINISH;
      end
      S_FINISH:
      begin
        next_s.status_valid = 1'b1;
        next_s.busy         = 1'b0;
        next_s.done         = 1'b1;
        next_s.state        = S_IDLE;
      end
    endcase

    // Read data sees this edge's writes, so no stale read after write
    if (rd_now)
      next_s.hrdata = read_reg(next_s, rd_addr);
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else if (ce_in)
      s <= next_s;
  end
endmodule

// *** tb/sarp_parser_sva.sv ***
// Purpose: Handshake and completion checks on the parser
// Assumes: Clock enable held high
// Notes:   Sees only top-level ports
module sarp_parser_sva
  import sarp_pkg::*;
(
  input wire logic                 clk_in,
  input wire logic                 resetn_in,
  input wire logic                 core_partial_in,
  input wire logic                 core_done_in,
  input wire logic                 core_wr_busy_in,
  input wire logic                 core_start_out,
  input wire sarp_pkg::sarp_kind_t core_kind_out,
  input wire logic                 core_aad_en_out,
  input wire logic                 core_ccm_out,
  input wire logic                 iv_update_out,
  input wire logic                 status_valid_out
);
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Strobes are single-cycle
  start_pulse_a: assert property (core_start_out |=> !core_start_out)
    else $error("start pulse too long");
  status_pulse_a: assert property (status_valid_out |=> !status_valid_out)
    else $error("status pulse too long");
  // One IV update for each partial pass
  iv_follow_a: assert property (iv_update_out == $past(core_partial_in))
    else $error("iv update mismatch");
  // Status only once output writes have drained
  drain_first_a: assert property (status_valid_out |-> !$past(core_wr_busy_in, 2))
    else $error("status before drain");
  done_status_a: assert property (core_done_in |-> ##[2:12] status_valid_out)
    else $error("no status after done");
  start_quiet_a: assert property (core_start_out |=> !status_valid_out ##1 !status_valid_out)
    else $error("status too soon");
  // Field gating by request kind
  aad_gate_a: assert property (core_start_out && core_kind_out == KIND_CIPHER |-> !core_aad_en_out)
    else $error("aad on cipher");
  ccm_kind_a: assert property (core_start_out && core_ccm_out |-> core_kind_out == KIND_AEAD)
    else $error("ccm outside aead");
endmodule

bind sarp_parser sarp_parser_sva chk (.clk_in, .resetn_in, .core_partial_in, .core_done_in, .core_wr_busy_in,
  .core_start_out, .core_kind_out, .core_aad_en_out, .core_ccm_out, .iv_update_out, .status_valid_out);

// *** tb/sarp_core_model.sv ***
// Purpose: Behavioural crypto core and output writer
// Assumes: One request at a time, one-cycle start pulse
// Notes:   Tag verdict, error and drain time set by the bench
module sarp_core_model
(
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic       tag_ok_cfg_in,
  input  wire logic       error_cfg_in,
  input  wire logic [2:0] slow_in,
  output logic            partial_out,
  output logic            done_out,
  output logic            tag_ok_out,
  output logic            error_out,
  output logic            wr_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two partial passes, done, then a drain of slow_in cycles
  initial
  begin
    {partial_out, done_out, tag_ok_out, error_out, wr_busy_out} = '0;
    forever
    begin
      @(posedge clk_in);
      #1;
      if (start_in)
      begin
        repeat (2)
        begin
          @(posedge clk_in) partial_out <= 1'b1; // IV advanced
          @(posedge clk_in) partial_out <= 1'b0;
        end
        // Dst, tag and hash written while busy
        @(posedge clk_in) {done_out, wr_busy_out, tag_ok_out, error_out} <= {2'b11, tag_ok_cfg_in, error_cfg_in};
        // Verdict lines are only valid with done
        @(posedge clk_in) {done_out, tag_ok_out, error_out} <= {1'b0, ~tag_ok_cfg_in, ~error_cfg_in};
        repeat (slow_in) @(posedge clk_in);
        wr_busy_out <= 1'b0;
      end
    end
  end
endmodule

// *** tb/sym_aead_request_parser_test.sv ***
// Purpose: Self-checking bench for the request parser
// Assumes: Both stateless modes negotiated, sessions 3 and 5 live
// Notes:   Expected status comes from a check-order model
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module sym_aead_request_parser_test
  import sarp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, resetn_in = 0, hsel = 0, hwrite = 0, tag_ok = 0, cerr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
  logic        hready, partial, done, tok_w, err_w, busy, start, dec, aad, ccm, ivu, sv;
  logic [3:0]  code;
  sarp_kind_t  kind;
  int          mismatches = 0, n_compared = 0, seed = 32'h33bc2ff6;

  initial forever #10 clk_in = ~clk_in;

  sarp_parser #(.SESS_IDX_W(4)) uut (.clk_in, .resetn_in, .ce_in(1'b1), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(), .core_partial_in(partial), .core_done_in(done),
    .core_tag_ok_in(tok_w), .core_error_in(err_w), .core_wr_busy_in(busy), .core_start_out(start),
    .core_kind_out(kind), .core_decrypt_out(dec), .core_aad_en_out(aad), .core_ccm_out(ccm),
    .iv_update_out(ivu), .status_valid_out(sv), .status_code_out(code));
  sarp_core_model core (.clk_in, .start_in(start), .tag_ok_cfg_in(tag_ok), .error_cfg_in(cerr), .slow_in(slow),
    .partial_out(partial), .done_out(done), .tag_ok_out(tok_w), .error_out(err_w), .wr_busy_out(busy));

  // Single word transfer; read data lands in rdv
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  // Load one request, start it and compare with the model
  task automatic req(input int opc, flg, sid, sym, a0, aadl, input bit tok, ce, sh);
    int q[$], src, dst, i;
    logic [3:0] e;
    bit ae, sl, go, st;
    src = $random(seed) & 255; dst = sh ? src : src + 16; st = 0;
    ae = opc >> 8 == 2; sl = flg == 0;
    // IV or nonce length 12 suits both GCM and CCM
    if (ae && sl) q = '{a0, 16, opc & 1, 12, 16, aadl, src, dst};
    else if (ae) q = '{12, aadl, src, dst, 16, 0};
    else if (sym == 2 && sl) q = '{1, aadl, a0, 16, opc & 1, a0, 16, 1, 16, src, dst, 0, src, 0, src, aadl, 32, 0};
    else if (sym == 2) q = '{16, src, dst, 0, src, 0, src, aadl, 32, 0};
    else if (sl) q = '{a0, 16, opc & 1, 16, src, dst};
    else q = '{16, src, dst, 0};
    // Check order: unsupported, bad flag, session, AEAD room, core
    if (!(opc inside {OPC_CIPHER_ENCRYPT, OPC_CIPHER_DECRYPT, OPC_AEAD_ENCRYPT, OPC_AEAD_DECRYPT}) || sl && !a0)
      e = STATUS_UNSUPPORTED;
    else if (flg > 1) e = STATUS_ERROR;
    else if (!sl && !(sid inside {3, 5})) e = STATUS_INVALID_SESSION;
    else if (ae && dst < src + 16) e = STATUS_ERROR;
    else e = STATUS_OK;
    go = e == STATUS_OK;
    if (go && ce) e = STATUS_ERROR;
    else if (go && ae && opc[0] && !tok) e = STATUS_BAD_MESSAGE;
    tag_ok <= tok; cerr <= ce; slow <= 3'($random(seed));
    ahb(1, REG_OPCODE, opc);
    ahb(1, REG_FLAG, flg);
    ahb(1, REG_SESSION, sid);
    ahb(1, REG_SYM_OP, sym);
    // Words past each layout carry garbage that must be ignored
    for (i = 0; i < 18; i++) ahb(1, REG_FIXED_BASE + 8'(4 * i), i < q.size() ? q[i] : $random(seed));
    ahb(1, REG_CTRL, 32'h7);
    for (i = 0; i < 100 && sv !== 1'b1; i++)
    begin
      @(posedge clk_in);
      #1;
      if (start === 1'b1)
      begin
        st = 1;
        `CHK(kind, ae ? KIND_AEAD : sym == 2 ? KIND_CHAIN : KIND_CIPHER) // Kind
        `CHK(dec, opc[0]) // Direction
        `CHK(aad, (ae || sym == 2) && aadl > 0) // AAD gate
        `CHK(ccm, ae && (sl ? a0 == AEAD_ALGO_CCM : sid == 5)) // CCM nonce
      end
    end
    `CHK(sv, 1'b1) // Status arrived within the limit
    `CHK(st, go) // Core only for valid requests
    `CHK(code, e) // Status code
    ahb(0, REG_STATUS, 0);
    `CHK(rdv, {24'h0, e, 4'h2}) // Done and code
    ahb(0, ae ? REG_TAG_OFF : REG_HASH_OFF, 0);
    if (go && ae) `CHK(rdv, src) // Tag after result
    else if (go && sym == 2) `CHK(rdv, dst) // Hash after dst
    ahb(0, REG_IV_UPDATES, 0);
    `CHK(rdv, go ? 32'h2 : 32'h0) // One count per partial pass
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence: sessions, unmapped read, one request per case
  initial
  begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1;
    ahb(1, REG_SESS_CFG, 32'h0001_0003);
    ahb(1, REG_SESS_CFG, 32'h0003_0005);
    ahb(0, 8'hFC, 0);
    `CHK(rdv, 32'h0) // Unused words read as zero
    req(OPC_CIPHER_ENCRYPT, 1, 3, 1, 0, 0, 1, 0, 0); // Session cipher
    req(OPC_CIPHER_DECRYPT, 0, 0, 1, 1, 0, 1, 0, 0); // Stateless cipher
    req(OPC_CIPHER_ENCRYPT, 0, 0, 2, 1, 8, 1, 0, 0); // Stateless chain
    req(OPC_CIPHER_DECRYPT, 1, 3, 2, 0, 0, 1, 0, 0); // Chain without AAD
    req(OPC_AEAD_ENCRYPT, 1, 5, 1, 0, 4, 1, 0, 0); // CCM session
    req(OPC_AEAD_DECRYPT, 0, 0, 1, 1, 4, 0, 0, 0); // Tag mismatch
    req(OPC_AEAD_ENCRYPT, 0, 0, 1, 2, 4, 1, 0, 0); // Stateless CCM
    req(OPC_AEAD_DECRYPT, 1, 3, 1, 0, 0, 1, 0, 0); // Tag match
    req(OPC_CIPHER_ENCRYPT, 1, 9, 1, 0, 0, 1, 0, 0); // Unknown session
    req(OPC_AEAD_ENCRYPT, 0, 0, 1, 0, 0, 1, 0, 0); // No algorithm
    req(32'h300, 1, 3, 1, 0, 0, 1, 0, 0); // Foreign opcode
    req(OPC_CIPHER_ENCRYPT, 2, 3, 1, 0, 0, 1, 0, 0); // Bad flag
    req(OPC_AEAD_ENCRYPT, 1, 3, 1, 0, 0, 1, 0, 1); // Short dst
    req(OPC_CIPHER_DECRYPT, 1, 3, 2, 0, 2, 1, 1, 0); // Core failure
    results;
  end

  // About ten thousand cycles, far beyond the expected run
  initial
  begin
    #200000;
    mismatches++;
    results;
  end
endmodule
